// File: hw/pfs_consts.svh
// Purpose: Offsets, bit positions, reset value and timing figures of the status word
// Assumes: Included by the status word package and design modules
// Notes: Definitions only
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// ***********************************************************
// Register map
// ***********************************************************
`define PFS_STATUS_OFFSET 8'h06
`define PFS_STATUS_RESET 16'h0210

// ***********************************************************
// Field positions in the status word
// ***********************************************************
`define PFS_BIT_DETECTED_PARITY 4'hF
`define PFS_BIT_SIGNALED_SYSERR 4'hE
`define PFS_BIT_RX_MASTER_ABORT 4'hD
`define PFS_BIT_RX_TARGET_ABORT 4'hC
`define PFS_BIT_SIG_TARGET_ABORT 4'hB
`define PFS_BIT_MASTER_DATA_PARITY 4'h8
`define PFS_BIT_CAP_LIST 4'h4
`define PFS_BIT_INT_PENDING 4'h3
`define PFS_DEVSEL_HI 4'hA
`define PFS_DEVSEL_LO 4'h9
`define PFS_DEVSEL_MEDIUM 2'h1
`define PFS_BACK_TO_BACK_CAPABLE 1'h0
`define PFS_USER_FEATURE_SUPPORT 1'h0
`define PFS_FAST_CLOCK_CAPABLE 1'h0
`define PFS_CAP_LIST_PRESENT 1'h1
`define PFS_RESERVED_LOW 3'h0
`define PFS_FLAG_COUNT 6

// ***********************************************************
// Clock figures
// ***********************************************************
`define PFS_CORE_CLK_HZ 20000000
`define PFS_MAX_PCI_CLK_MHZ 33

`endif

// File: hw/pfs_flag_cell.sv
// Purpose: One sticky flag, set by hardware and cleared by a write of one
// Assumes: Set and clear are one-cycle strobes on core_clk
// Notes: A set in the same cycle as a clear wins
module pfs_flag_cell
  import pfs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic set_event,
  input wire logic clear_req,
  output logic flag
);

  // ***********************************************************
  // Flag storage
  // ***********************************************************
  // Set ahead of clear so that no error slips past software
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag <= 1'h0;
    end else if (set_event) begin
      flag <= 1'h1;
    end else if (clear_req) begin
      flag <= 1'h0;
    end
  end

endmodule

// File: hw/pfs_pkg.sv
// Purpose: Types shared by the status word design files
// Assumes: Constants come from pfs_consts.svh
// Notes: Flag order matches the generate loop in the top module
`include "pfs_consts.svh"

package pfs_pkg;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef logic [15:0] pfs_word_t;

  // Index of each sticky error flag
  typedef enum {
    pfs_detected_parity,
    pfs_signaled_syserr,
    pfs_rx_master_abort,
    pfs_rx_target_abort,
    pfs_sig_target_abort,
    pfs_master_data_parity
  } pfs_flag_t;

endpackage

// File: hw/pfs_status_reg.sv
// Purpose: Status word of the function's configuration header
// Assumes: Event strobes and command bits come from logic on core_clk
// Notes: Command register and transaction engine live elsewhere

`include "pfs_consts.svh"

module pfs_status_reg
  import pfs_pkg::*;
#(
  parameter int INT_SOURCES = 4
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic cmd_int_mask,
  input wire logic parity_response_enable,
  input wire logic syserr_driver_enable,
  input wire logic ev_addr_parity_err,
  input wire logic ev_data_parity_err,
  input wire logic serr_request,
  input wire logic ev_master_abort,
  input wire logic ev_target_abort_rx,
  input wire logic ev_target_abort_sig,
  input wire logic ev_perr_seen,
  input wire logic bus_master_phase,
  input wire logic [INT_SOURCES-1:0] int_condition,
  input wire logic [INT_SOURCES-1:0] int_enable,
  output logic serr_out,
  output logic serr_oe,
  output logic intx_out,
  output logic intx_oe
);

  // ***********************************************************
  // Helpers
  // ***********************************************************
  // Bit position of each sticky flag, used for clear and for readback
  function automatic logic [3:0] flag_pos(input int idx);
    logic [3:0] pos;
    pos = `PFS_BIT_DETECTED_PARITY;
    case (idx)
      pfs_detected_parity: pos = `PFS_BIT_DETECTED_PARITY;
      pfs_signaled_syserr: pos = `PFS_BIT_SIGNALED_SYSERR;
      pfs_rx_master_abort: pos = `PFS_BIT_RX_MASTER_ABORT;
      pfs_rx_target_abort: pos = `PFS_BIT_RX_TARGET_ABORT;
      pfs_sig_target_abort: pos = `PFS_BIT_SIG_TARGET_ABORT;
      pfs_master_data_parity: pos = `PFS_BIT_MASTER_DATA_PARITY;
      default: pos = `PFS_BIT_DETECTED_PARITY;
    endcase
    return pos;
  endfunction

  // ***********************************************************
  // Declarations
  // ***********************************************************
  logic hit;
  logic wr_hit;
  logic serr_fire;
  logic int_pending;
  logic next_int_pending;
  logic [`PFS_FLAG_COUNT-1:0] flag_set;
  logic [`PFS_FLAG_COUNT-1:0] flag_clr;
  logic [`PFS_FLAG_COUNT-1:0] flags;
  pfs_word_t status_word;

  // ***********************************************************
  // Access decode
  // ***********************************************************
  // Only the high byte holds clearable flags, so only its lane clears
  assign hit = (cfg_addr == `PFS_STATUS_OFFSET);
  assign wr_hit = cfg_wr && hit && cfg_be[1];

  // ***********************************************************
  // Event sources
  // ***********************************************************
  // Driver enable gates the pin and the flag with one term
  assign serr_fire = serr_request && syserr_driver_enable;

  // Event to flag mapping, in the order of the flag index type
  always_comb begin
    flag_set = '0;
    flag_set[pfs_detected_parity] = ev_addr_parity_err || ev_data_parity_err;
    flag_set[pfs_signaled_syserr] = serr_fire;
    flag_set[pfs_rx_master_abort] = ev_master_abort;
    flag_set[pfs_rx_target_abort] = ev_target_abort_rx;
    flag_set[pfs_sig_target_abort] = ev_target_abort_sig;
    // All three conditions must hold together
    flag_set[pfs_master_data_parity] =
      ev_perr_seen && bus_master_phase && parity_response_enable;
  end

  // ***********************************************************
  // Sticky flags
  // ***********************************************************
  // One cell per flag; a zero in the written data leaves the bit alone
  genvar gi;
  generate
    for (gi = 0; gi < `PFS_FLAG_COUNT; gi++) begin : g_flag
      assign flag_clr[gi] = wr_hit && cfg_wdata[flag_pos(gi)];
      pfs_flag_cell u_cell (
        .core_clk(core_clk),
        .reset(reset),
        .set_event(flag_set[gi]),
        .clear_req(flag_clr[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // ***********************************************************
  // Interrupt pending
  // ***********************************************************
  // Mask is deliberately not a term here: pending keeps tracking
  assign next_int_pending = |(int_condition & int_enable);

  // Pending follows live conditions, one cycle behind
  always_ff @(posedge core_clk) begin
    if (reset) begin
      int_pending <= 1'h0;
    end else begin
      int_pending <= next_int_pending;
    end
  end

  // ***********************************************************
  // Status word composition
  // ***********************************************************
  // Fixed fields first, then the flags at their positions
  always_comb begin
    status_word = '0;
    status_word[2:0] = `PFS_RESERVED_LOW;
    status_word[`PFS_BIT_INT_PENDING] = int_pending;
    status_word[`PFS_BIT_CAP_LIST] = `PFS_CAP_LIST_PRESENT;
    status_word[5] = `PFS_FAST_CLOCK_CAPABLE;
    status_word[6] = `PFS_USER_FEATURE_SUPPORT;
    status_word[7] = `PFS_BACK_TO_BACK_CAPABLE;
    status_word[`PFS_DEVSEL_HI:`PFS_DEVSEL_LO] = `PFS_DEVSEL_MEDIUM;
    for (int i = 0; i < `PFS_FLAG_COUNT; i++) begin
      status_word[flag_pos(i)] = flags[i];
    end
  end

  // ***********************************************************
  // Read path
  // ***********************************************************
  // Registered answer; unmapped offsets read zero, reads touch no flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_rdata <= '0;
    end else if (cfg_rd) begin
      cfg_rdata <= hit ? status_word : 16'h0000;
    end
  end

  // Valid marks the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_rvalid <= 1'h0;
    end else begin
      cfg_rvalid <= cfg_rd;
    end
  end

  // ***********************************************************
  // Open-drain pins
  // ***********************************************************
  // Both pins only ever pull low; the level stays zero from reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      serr_out <= 1'h0;
      intx_out <= 1'h0;
    end else begin
      serr_out <= 1'h0;
      intx_out <= 1'h0;
    end
  end

  // System error drive, only with the driver enabled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      serr_oe <= 1'h0;
    end else begin
      serr_oe <= serr_fire;
    end
  end

  // INTx drive; mask at zero after reset leaves it enabled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      intx_oe <= 1'h0;
    end else begin
      intx_oe <= int_pending && !cmd_int_mask;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // A clearing write to the detected parity bit with no new event
  sequence seq_clear_parity;
    wr_hit && cfg_wdata[`PFS_BIT_DETECTED_PARITY] && !flag_set[pfs_detected_parity];
  endsequence

  // A zero written over a set parity flag
  sequence seq_zero_parity;
    wr_hit && !cfg_wdata[`PFS_BIT_DETECTED_PARITY] && flags[pfs_detected_parity];
  endsequence

  // A read answered at the status offset
  sequence seq_status_read;
    cfg_rd && hit ##1 cfg_rvalid;
  endsequence

  AST_W1C_CLEAR: assert property (
    seq_clear_parity |=> !status_word[`PFS_BIT_DETECTED_PARITY])
    else $error("write of one did not clear the parity flag");

  AST_W0_KEEP: assert property (
    seq_zero_parity |=> status_word[`PFS_BIT_DETECTED_PARITY])
    else $error("write of zero disturbed the parity flag");

  AST_READ_NO_SIDE: assert property (
    (cfg_rd && !cfg_wr && flag_set == '0) |=> $stable(flags))
    else $error("read changed a status flag");

  AST_READ_DATA: assert property (
    (cfg_rd && hit) |=> (cfg_rvalid && cfg_rdata == $past(status_word)))
    else $error("read data does not match the status word");

  AST_PARITY_SET: assert property (
    (ev_addr_parity_err || ev_data_parity_err) |=> flags[pfs_detected_parity])
    else $error("parity error did not set bit 15");

  AST_SERR_SET: assert property (
    (serr_request && syserr_driver_enable) |=> (flags[pfs_signaled_syserr] && serr_oe))
    else $error("system error did not set bit 14 and drive the pin");

  AST_SERR_GATED: assert property (
    !syserr_driver_enable |=> !serr_oe)
    else $error("system error driven while its driver is disabled");

  AST_RX_MASTER_ABORT_FLAG_SET: assert property (
    ev_master_abort |=> status_word[`PFS_BIT_RX_MASTER_ABORT])
    else $error("master abort did not set bit 13");

  AST_TABORT_RX_SET: assert property (
    ev_target_abort_rx |=> status_word[`PFS_BIT_RX_TARGET_ABORT])
    else $error("received target abort did not set bit 12");

  AST_SIG_TARGET_ABORT_FLAG_SET: assert property (
    ev_target_abort_sig |=> status_word[`PFS_BIT_SIG_TARGET_ABORT])
    else $error("signalled target abort did not set bit 11");

  AST_FIXED_FIELDS: assert property (
    seq_status_read |->
      (cfg_rdata[10:9] == 2'h1 && cfg_rdata[7:4] == 4'h1 && cfg_rdata[2:0] == 3'h0))
    else $error("fixed status fields read wrong");

  AST_MASTER_DATA_PARITY_FLAG_SET: assert property (
    (ev_perr_seen && bus_master_phase && parity_response_enable)
      |=> status_word[`PFS_BIT_MASTER_DATA_PARITY])
    else $error("master data parity did not set bit 8");

  AST_MASTER_DATA_PARITY_FLAG_OFF: assert property (
    (!parity_response_enable && !flags[pfs_master_data_parity])
      |=> !flags[pfs_master_data_parity])
    else $error("bit 8 set with parity response disabled");

  AST_HARDWIRED: assert property (
    (cfg_wr && hit && cfg_wdata[7:5] == 3'h7) |=> (status_word[7:5] == 3'h0))
    else $error("hardwired zero bits became writable");

  AST_CAP_LIST: assert property (
    (cfg_wr && hit && !cfg_wdata[4]) |=> status_word[`PFS_BIT_CAP_LIST])
    else $error("capabilities bit did not read one");

  AST_INTX_DRIVE: assert property (
    intx_oe |-> ($past(int_pending) && !$past(cmd_int_mask)))
    else $error("INTx driven without pending or while masked");

  AST_INTX_ENABLED: assert property (
    (int_pending && !cmd_int_mask) |=> intx_oe)
    else $error("unmasked pending interrupt not driven");

  AST_MASK_KEEPS: assert property (
    ($rose(cmd_int_mask) && next_int_pending) ##1 next_int_pending |=> int_pending)
    else $error("mask disturbed the pending bit");

  AST_DISABLED_NO_PEND: assert property (
    ((int_condition & int_enable) == '0) |=> !int_pending)
    else $error("pending set without an enabled condition");

  AST_SET_WINS: assert property (
    (flag_set[pfs_detected_parity] && flag_clr[pfs_detected_parity])
      |=> flags[pfs_detected_parity] [*2] or
      (flags[pfs_detected_parity] ##1 flag_clr[pfs_detected_parity]))
    else $error("clear beat a simultaneous set");

  AST_LOW_LANE_KEEP: assert property (
    (cfg_wr && !cfg_be[1] && flag_set == '0) |=> $stable(flags))
    else $error("write on the low lane changed a flag");

  AST_RVALID_PULSE: assert property (
    !cfg_rd |=> !cfg_rvalid)
    else $error("read answer without a read strobe");

  AST_MASTER_DATA_PARITY_FLAG_NOT_MASTER: assert property (
    (!bus_master_phase && !flags[pfs_master_data_parity])
      |=> !flags[pfs_master_data_parity])
    else $error("bit 8 set while not bus master");

  AST_INTX_MASKED: assert property (
    cmd_int_mask |=> !intx_oe)
    else $error("INTx driven while masked");

  AST_PEND_TRACKS: assert property (
    next_int_pending |=> int_pending)
    else $error("enabled condition did not raise pending");

endmodule

// File: tb/pci_function_status_register_bench.sv
// Purpose: Self-checking bench for the function status word
// Assumes: Host model drives configuration cycles, bench drives event strobes
// Notes: Expected words are built from the reset value and bit positions
`include "pfs_consts.svh"
module pci_function_status_register_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************************
  // Signals
  // ***********************************************************
  logic core_clk, reset, cfg_rd, cfg_wr, cfg_rvalid, cmd_int_mask;
  logic parity_response_enable, syserr_driver_enable, bus_master_phase;
  logic serr_out, serr_oe, intx_out, intx_oe;
  logic [7:0] cfg_addr;
  logic [1:0] cfg_be;
  logic [15:0] cfg_wdata, cfg_rdata;
  logic [6:0] ev;
  logic [3:0] int_condition, int_enable;
  int failures = 0;
  int n_checks = 0;
  localparam int POS[7] = '{15, 15, 14, 13, 12, 11, 8};
  localparam logic [15:0] RST = `PFS_STATUS_RESET;

  pfs_host_model host_u (.core_clk(core_clk), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid));

  pfs_status_reg #(.INT_SOURCES(4)) dut_u (.core_clk(core_clk), .reset(reset),
    .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .cmd_int_mask(cmd_int_mask), .parity_response_enable(parity_response_enable),
    .syserr_driver_enable(syserr_driver_enable), .ev_addr_parity_err(ev[0]),
    .ev_data_parity_err(ev[1]), .serr_request(ev[2]), .ev_master_abort(ev[3]),
    .ev_target_abort_rx(ev[4]), .ev_target_abort_sig(ev[5]), .ev_perr_seen(ev[6]),
    .bus_master_phase(bus_master_phase), .int_condition(int_condition),
    .int_enable(int_enable), .serr_out(serr_out), .serr_oe(serr_oe),
    .intx_out(intx_out), .intx_oe(intx_oe));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read one offset and compare the whole word; the answer must be on time
  task automatic expect_at(input logic [7:0] a, input string name, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host_u.rd(a, d, ok);
    check("read answer", {15'h0000, ok}, 16'h0001);
    check(name, d, exp);
  endtask

  // Strobe one event for a single cycle; SERR must follow only when enabled
  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
    #1;
    check("serr drive", {15'h0000, serr_oe}, {15'h0000, i == 2 && syserr_driver_enable});
    check("open drain levels", {14'h0000, serr_out, intx_out}, 16'h0000);
  endtask

  task automatic settle_int(input string name, input logic exp);
    repeat (3) @(posedge core_clk);
    #1;
    check(name, {15'h0000, intx_oe}, {15'h0000, exp});
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_reset();
    expect_at(`PFS_STATUS_OFFSET, "reset word", RST);
    host_u.wr(`PFS_STATUS_OFFSET, 2'h3, 16'hFFFF);
    expect_at(`PFS_STATUS_OFFSET, "fixed bits after write", RST);
    expect_at(8'h04, "unmapped read", 16'h0000);
    $display("test reset done");
  endtask

  // Every event sets its own bit, survives reads and ignored writes, then clears
  task automatic t_flags();
    logic [15:0] w;
    for (int i = 0; i < 7; i++) begin
      w = RST | (16'h0001 << POS[i]);
      pulse(i);
      expect_at(`PFS_STATUS_OFFSET, "flag set", w);
      expect_at(`PFS_STATUS_OFFSET, "flag after read", w);
      host_u.wr(`PFS_STATUS_OFFSET, 2'h1, 16'hFFFF);
      host_u.wr(`PFS_STATUS_OFFSET, 2'h3, 16'h0000);
      expect_at(`PFS_STATUS_OFFSET, "flag after zero write", w);
      host_u.wr(`PFS_STATUS_OFFSET, 2'h3, 16'h0001 << POS[i]);
      expect_at(`PFS_STATUS_OFFSET, "flag cleared", RST);
    end
    $display("test flags done");
  endtask

  // Events whose qualifiers are off leave the word untouched
  task automatic t_qualify();
    @(posedge core_clk);
    syserr_driver_enable <= 1'b0;
    pulse(2);
    expect_at(`PFS_STATUS_OFFSET, "serr disabled", RST);
    @(posedge core_clk);
    parity_response_enable <= 1'b0;
    pulse(6);
    expect_at(`PFS_STATUS_OFFSET, "parity response off", RST);
    @(posedge core_clk);
    parity_response_enable <= 1'b1;
    bus_master_phase <= 1'b0;
    pulse(6);
    expect_at(`PFS_STATUS_OFFSET, "not bus master", RST);
    @(posedge core_clk);
    bus_master_phase <= 1'b1;
    syserr_driver_enable <= 1'b1;
    $display("test qualify done");
  endtask

  // A clear landing in the same cycle as the set must not lose the error
  task automatic t_race();
    fork
      host_u.wr(`PFS_STATUS_OFFSET, 2'h3, 16'h8000);
      pulse(0);
    join
    expect_at(`PFS_STATUS_OFFSET, "set beats clear", RST | 16'h8000);
    host_u.wr(`PFS_STATUS_OFFSET, 2'h2, 16'h8000);
    expect_at(`PFS_STATUS_OFFSET, "clear after race", RST);
    $display("test race done");
  endtask

  task automatic t_intr();
    @(posedge core_clk);
    int_enable <= 4'h5;
    int_condition <= 4'hA;
    settle_int("disabled source", 1'b0);
    expect_at(`PFS_STATUS_OFFSET, "disabled source word", RST);
    @(posedge core_clk);
    int_condition <= 4'hB;
    settle_int("enabled source", 1'b1);
    host_u.wr(`PFS_STATUS_OFFSET, 2'h3, 16'h0008);
    expect_at(`PFS_STATUS_OFFSET, "pending not writable", RST | 16'h0008);
    @(posedge core_clk);
    cmd_int_mask <= 1'b1;
    settle_int("masked", 1'b0);
    expect_at(`PFS_STATUS_OFFSET, "pending while masked", RST | 16'h0008);
    @(posedge core_clk);
    cmd_int_mask <= 1'b0;
    int_condition <= 4'h0;
    settle_int("condition gone", 1'b0);
    expect_at(`PFS_STATUS_OFFSET, "pending gone", RST);
    $display("test interrupt done");
  endtask

  // A reset in mid-run must drop sticky flags back to the reset word
  task automatic t_rerun();
    pulse(3);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    expect_at(`PFS_STATUS_OFFSET, "word after mid reset", RST);
    $display("test mid reset done");
  endtask

  // ***********************************************************
  // Sequence and verdict
  // ***********************************************************
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    ev = 7'h00;
    cmd_int_mask = 1'b0;
    parity_response_enable = 1'b1;
    syserr_driver_enable = 1'b1;
    bus_master_phase = 1'b1;
    int_condition = 4'h0;
    int_enable = 4'h0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_flags();
    t_qualify();
    t_race();
    t_intr();
    t_rerun();
    test_done();
  end

  // Whole run is under two hundred cycles; this leaves ample margin
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule

// File: tb/pfs_host_model.sv
// Purpose: Host side of the configuration bus that reaches the status word
// Assumes: Requests are taken at a rising edge, read answer stands one cycle later
// Notes: Released lines show the inverse of their last value so stale data never matches
module pfs_host_model (
  input wire logic core_clk,
  output logic [7:0] cfg_addr,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [1:0] cfg_be,
  output logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************************
  // Idle state
  // ***********************************************************
  initial begin
    cfg_addr = 8'h00;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_be = 2'h0;
    cfg_wdata = 16'h0000;
  end

  // ***********************************************************
  // Bus cycles
  // ***********************************************************
  // One-cycle read; the answer is due exactly one edge after it is taken
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge core_clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    #1;
    ok = cfg_rvalid;
    d = cfg_rdata;
  endtask

  // Write of ones clears flags, so released data is inverted, not held
  task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    @(posedge core_clk);
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_addr <= ~a;
    cfg_be <= ~b;
    cfg_wdata <= ~d;
  endtask
endmodule
